// >>> logic/bss_sequencer.sv
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
module bss_sequencer #(
   parameter int TICK_CYC = bss_pkg::TICK_CYC,
   parameter bit VARIANT_C = 1'b0
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire bss_pkg::bss_in_s burner_in,
   output bss_pkg::bss_out_s burner_out,
   output logic lockout,
   output logic hold,
   output logic [7:0] fault_code
);

   localparam int TW = bss_pkg::TW;

   bss_pkg::bss_in_s pin;
   bss_pkg::bss_state_e state;
   bss_pkg::bss_state_e next_state;
   logic [7:0] next_fault;
   logic [31:0] tick_cnt;
   logic tick;
   logic [TW-1:0] st_t;
   logic [TW-1:0] hold_t;
   logic [TW-1:0] show_t;
   logic [TW-1:0] on_t;
   logic [TW-1:0] off_t;
   logic [TW-1:0] op_t;
   logic [2:0] link_ref;
   logic perm;
   logic rb_q;
   logic [bss_pkg::POST_W-1:0] post_s;
   logic [bss_pkg::PURGE_W-1:0] purge_s;
   logic st_clr;

   // ------------------------------------------------------------
   // Pin synchronisation
   // ------------------------------------------------------------
   bss_sync #(
      .W($bits(bss_pkg::bss_in_s))
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d(burner_in),
      .q(pin)
   );

   // ------------------------------------------------------------
   // Decoding
   // ------------------------------------------------------------
   wire chg = (next_state != state);
   wire rb_rise = pin.reset_btn & ~rb_q;
   wire [2:0] links = {pin.pilot_trial_length_link, pin.flame_failure_action_link,
                       pin.airflow_failure_action_link};
   wire link_bad = (links != link_ref) && (op_t >= bss_pkg::LINK_LOCK_T);
   wire long_trial = pin.pilot_trial_length_link;
   wire [TW-1:0] pilot_t = long_trial ? bss_pkg::PILOT_LONG_T : bss_pkg::PILOT_SHORT_T;
   wire [TW-1:0] test_t = long_trial ? bss_pkg::TEST_LONG_T : bss_pkg::TEST_SHORT_T;
   // One tick early so the lockout lands inside the rated response
   wire [TW-1:0] flame_failure_response_t = (pin.flame_failure_response_slow ? bss_pkg::FLAME_FAILURE_RESPONSE_SLOW_T : bss_pkg::FLAME_FAILURE_RESPONSE_FAST_T)
                          - TW'(1);
   wire [TW-1:0] purge_t = TW'(purge_s) * TW'(bss_pkg::TPS);
   wire [TW-1:0] post_t = TW'(post_s) * TW'(bss_pkg::TPS);
   wire flame_lost = ~pin.flame && (off_t >= flame_failure_response_t);
   wire air_late = ~pin.airflow_interlock && (st_t >= bss_pkg::AIRFLOW_T);
   wire in_pre = (state == bss_pkg::ST_PREPURGE);
   wire in_pilot = (state == bss_pkg::ST_PILOT);
   wire frz_pre = in_pre & pin.test_sel;
   wire frz_pilot = in_pilot & pin.test_sel & (st_t < test_t);
   wire ready_go = pin.heat_call & pin.limits_ok & pin.preign_closed & ~pin.test_sel;
   wire wr = psel & penable & pwrite;
   wire hit_post = (paddr == bss_pkg::REG_POST);
   wire hit_purge = (paddr == bss_pkg::REG_PURGE);
   wire hit_stat = (paddr == bss_pkg::REG_STATUS);
   wire hit = hit_post | hit_purge | hit_stat;

   // ------------------------------------------------------------
   // Sequence decisions
   // ------------------------------------------------------------
   // Lockout and line checks outrank the per-state sequence
   always_comb begin
      next_state = state;
      next_fault = fault_code;
      st_clr = 1'b0;
      if (state == bss_pkg::ST_LOCK) begin
         if (rb_rise && !perm) begin
            next_state = bss_pkg::ST_INIT;
            next_fault = bss_pkg::FLT_NONE;
         end
      end else if (link_bad) begin
         next_state = bss_pkg::ST_LOCK;
         next_fault = bss_pkg::FLT_LINK;
      end else if (!pin.line_ok && state != bss_pkg::ST_INIT) begin
         next_state = bss_pkg::ST_INIT;
      end else begin
         unique case (state)
            bss_pkg::ST_INIT: begin
               st_clr = ~pin.line_ok;
               if (hold_t >= bss_pkg::HOLD_MAX_T) begin
                  next_state = bss_pkg::ST_LOCK;
                  next_fault = bss_pkg::FLT_LINE;
               end else if (pin.line_ok && st_t >= bss_pkg::INIT_T) begin
                  next_state = bss_pkg::ST_STANDBY;
               end
            end
            bss_pkg::ST_STANDBY: begin
               if (on_t >= bss_pkg::STBY_FLAME_T) begin
                  next_state = bss_pkg::ST_LOCK;
                  next_fault = bss_pkg::FLT_FLAME_UNEXP;
               end else if (ready_go) begin
                  next_state = bss_pkg::ST_PREPURGE;
               end
            end
            bss_pkg::ST_PREPURGE: begin
               if (on_t >= bss_pkg::PURGE_FLAME_T) begin
                  next_state = bss_pkg::ST_LOCK;
                  next_fault = bss_pkg::FLT_FLAME_UNEXP;
               end else if (!pin.preign_closed) begin
                  next_state = bss_pkg::ST_LOCK;
                  next_fault = bss_pkg::FLT_PREIGN;
               end else if (!pin.heat_call || !pin.limits_ok) begin
                  next_state = bss_pkg::ST_POST;
               end else if (air_late && pin.airflow_failure_action_link) begin
                  st_clr = 1'b1;
               end else if (air_late) begin
                  next_state = bss_pkg::ST_LOCK;
                  next_fault = bss_pkg::FLT_AIRFLOW;
               end else if (st_t >= purge_t && st_t >= bss_pkg::AIRFLOW_T) begin
                  next_state = bss_pkg::ST_PILOT;
               end
            end
            bss_pkg::ST_PILOT: begin
               // Pre-ignition interlock is not looked at here
               if (!pin.heat_call || !pin.limits_ok) begin
                  next_state = bss_pkg::ST_POST;
               end else if (pin.test_sel && off_t >= bss_pkg::FLAMEOUT_TEST_T) begin
                  next_state = bss_pkg::ST_LOCK;
                  next_fault = bss_pkg::FLT_FLAME_ABS;
               end else if (st_t >= pilot_t && pin.flame) begin
                  next_state = bss_pkg::ST_MAIN;
               end else if (st_t >= pilot_t) begin
                  next_state = bss_pkg::ST_LOCK;
                  next_fault = bss_pkg::FLT_FLAME_ABS;
               end
            end
            bss_pkg::ST_MAIN, bss_pkg::ST_RUN: begin
               if (flame_lost && pin.flame_failure_action_link) begin
                  next_state = bss_pkg::ST_POST;
               end else if (flame_lost) begin
                  next_state = bss_pkg::ST_LOCK;
                  next_fault = bss_pkg::FLT_FLAME_ABS;
               end else if (!pin.heat_call || !pin.limits_ok) begin
                  next_state = bss_pkg::ST_POST;
               end else if (state == bss_pkg::ST_MAIN && st_t >= bss_pkg::MAIN_T) begin
                  next_state = bss_pkg::ST_RUN;
               end
            end
            bss_pkg::ST_POST: begin
               if (!pin.preign_closed && st_t >= bss_pkg::PREIGN_T) begin
                  next_state = bss_pkg::ST_LOCK;
                  next_fault = bss_pkg::FLT_PREIGN;
               end else if (st_t >= post_t) begin
                  next_state = bss_pkg::ST_STANDBY;
               end
            end
            default: begin
               next_state = bss_pkg::ST_LOCK;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Common timebase
   // ------------------------------------------------------------
   // Every sequence timer counts these ticks, so they never drift apart
   assign tick = (tick_cnt == 32'(TICK_CYC - 1));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt <= 32'h0;
      end else begin
         tick_cnt <= tick ? 32'h0 : tick_cnt + 32'h1;
      end
   end

   // ------------------------------------------------------------
   // State and state timer
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= bss_pkg::ST_INIT;
         fault_code <= bss_pkg::FLT_NONE;
         st_t <= '0;
         rb_q <= 1'b0;
      end else begin
         state <= next_state;
         fault_code <= next_fault;
         rb_q <= pin.reset_btn;
         if (chg || st_clr) begin
            st_t <= '0;
         end else if (tick && !frz_pre && !frz_pilot && st_t != '1) begin
            st_t <= st_t + TW'(1);
         end
      end
   end

   // ------------------------------------------------------------
   // Hold and flame timers
   // ------------------------------------------------------------
   // Flame timers run on continuous presence or absence only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_t <= '0;
         show_t <= '0;
         on_t <= '0;
         off_t <= '0;
      end else begin
         if (state != bss_pkg::ST_INIT || pin.line_ok) begin
            hold_t <= '0;
         end else if (tick && hold_t != '1) begin
            hold_t <= hold_t + TW'(1);
         end
         if (!pin.line_ok) begin
            show_t <= bss_pkg::HOLD_SHOW_T;
         end else if (tick && show_t != '0) begin
            show_t <= show_t - TW'(1);
         end
         if (chg || !pin.flame) begin
            on_t <= '0;
         end else if (tick && on_t != '1) begin
            on_t <= on_t + TW'(1);
         end
         if (chg || pin.flame) begin
            off_t <= '0;
         end else if (tick && off_t != '1) begin
            off_t <= off_t + TW'(1);
         end
      end
   end

   // ------------------------------------------------------------
   // Configuration link supervision
   // ------------------------------------------------------------
   // Early changes are adopted; the reference freezes at 200 hours.
   // Only power-on reset clears the permanent flag, never the button.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op_t <= '0;
         link_ref <= 3'h0;
         perm <= 1'b0;
      end else begin
         if (tick && op_t != bss_pkg::LINK_LOCK_T) begin
            op_t <= op_t + TW'(1);
         end
         if (op_t < bss_pkg::LINK_LOCK_T) begin
            link_ref <= links;
         end
         if (link_bad) begin
            perm <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Outputs, registered; burner outputs and lockout from the next state
   // ------------------------------------------------------------
   wire n_pre = (next_state == bss_pkg::ST_PREPURGE);
   wire n_pilot = (next_state == bss_pkg::ST_PILOT);
   wire n_main = (next_state == bss_pkg::ST_MAIN);
   wire n_run = (next_state == bss_pkg::ST_RUN);
   wire n_post = (next_state == bss_pkg::ST_POST);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         burner_out <= '0;
         lockout <= 1'b0;
         hold <= 1'b0;
      end else begin
         burner_out.blower <= n_pre | n_pilot | n_main | n_run | n_post;
         burner_out.ignition <= n_pilot;
         burner_out.pilot_interrupt <= n_pilot | n_main;
         burner_out.pilot_intermit <= ~VARIANT_C & (n_pilot | n_main | n_run);
         burner_out.main_valve <= n_main | n_run;
         burner_out.delayed_main <= VARIANT_C & n_run;
         lockout <= (next_state == bss_pkg::ST_LOCK);
         hold <= ~pin.line_ok | (show_t != '0);
      end
   end

   // ------------------------------------------------------------
   // APB slave, no wait states
   // ------------------------------------------------------------
   // Read data is caught in the setup cycle so it comes from flops
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~hit;
   wire [31:0] status = {16'h0, fault_code, 2'h0, perm, lockout, hold, state};
   wire [31:0] rd_mux = hit_post ? 32'(post_s) :
                        hit_purge ? 32'(purge_s) :
                        hit_stat ? status : 32'h0;
   wire [bss_pkg::PURGE_W-1:0] pg_in = pwdata[bss_pkg::PURGE_W-1:0];
   wire [bss_pkg::POST_W-1:0] po_in = pwdata[bss_pkg::POST_W-1:0];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
         post_s <= bss_pkg::POST_RST;
         purge_s <= bss_pkg::PURGE_RST;
      end else begin
         if (psel && !penable) begin
            prdata <= rd_mux;
         end
         if (wr && hit_post) begin
            post_s <= (32'(po_in) > 32'(bss_pkg::POST_MAX_S)) ?
                      bss_pkg::POST_W'(bss_pkg::POST_MAX_S) : po_in;
         end
         // Purge time is clamped to the range a timer card can select
         if (wr && hit_purge) begin
            if (32'(pg_in) < 32'(bss_pkg::PURGE_MIN_S)) begin
               purge_s <= bss_pkg::PURGE_W'(bss_pkg::PURGE_MIN_S);
            end else if (32'(pg_in) > 32'(bss_pkg::PURGE_MAX_S)) begin
               purge_s <= bss_pkg::PURGE_W'(bss_pkg::PURGE_MAX_S);
            end else begin
               purge_s <= pg_in;
            end
         end
      end
   end

endmodule : bss_sequencer

// >>> inc/bss_pkg.sv
package bss_pkg;

   // ------------------------------------------------------------
   // Timebase: one tick every 0.1 s at 100 MHz
   // ------------------------------------------------------------
   localparam int CLK_NS = 10;
   localparam int TICK_NS = 100_000_000;
   localparam int TICK_CYC = TICK_NS / CLK_NS;
   localparam int TPS = 1_000_000_000 / TICK_NS;
   localparam int TW = 24;

   // ------------------------------------------------------------
   // Sequence times, in their own units
   // ------------------------------------------------------------
   localparam int INIT_S = 10;
   localparam int HOLD_SHOW_S = 5;
   localparam int HOLD_MAX_S = 240;
   localparam int AIRFLOW_S = 10;
   localparam int PILOT_LONG_S = 10;
   localparam int PILOT_SHORT_S = 4;
   localparam int TEST_LONG_S = 8;
   localparam int TEST_SHORT_S = 3;
   localparam int FLAMEOUT_TEST_S = 15;
   localparam int MAIN_S = 10;
   localparam int STBY_FLAME_S = 240;
   localparam int PURGE_FLAME_S = 30;
   localparam int PREIGN_S = 5;
   localparam int LINK_LOCK_H = 200;
   localparam int FLAME_FAILURE_RESPONSE_FAST_DS = 8;
   localparam int FLAME_FAILURE_RESPONSE_SLOW_DS = 30;
   localparam int PURGE_MIN_S = 2;
   localparam int PURGE_MAX_S = 1800;
   localparam int POST_MAX_S = 3600;

   // ------------------------------------------------------------
   // Same times as tick counts
   // ------------------------------------------------------------
   localparam logic [TW-1:0] INIT_T = TW'(INIT_S * TPS);
   localparam logic [TW-1:0] HOLD_SHOW_T = TW'(HOLD_SHOW_S * TPS);
   localparam logic [TW-1:0] HOLD_MAX_T = TW'(HOLD_MAX_S * TPS);
   localparam logic [TW-1:0] AIRFLOW_T = TW'(AIRFLOW_S * TPS);
   localparam logic [TW-1:0] PILOT_LONG_T = TW'(PILOT_LONG_S * TPS);
   localparam logic [TW-1:0] PILOT_SHORT_T = TW'(PILOT_SHORT_S * TPS);
   localparam logic [TW-1:0] TEST_LONG_T = TW'(TEST_LONG_S * TPS);
   localparam logic [TW-1:0] TEST_SHORT_T = TW'(TEST_SHORT_S * TPS);
   localparam logic [TW-1:0] FLAMEOUT_TEST_T = TW'(FLAMEOUT_TEST_S * TPS);
   localparam logic [TW-1:0] MAIN_T = TW'(MAIN_S * TPS);
   localparam logic [TW-1:0] STBY_FLAME_T = TW'(STBY_FLAME_S * TPS);
   localparam logic [TW-1:0] PURGE_FLAME_T = TW'(PURGE_FLAME_S * TPS);
   localparam logic [TW-1:0] PREIGN_T = TW'(PREIGN_S * TPS);
   localparam logic [TW-1:0] LINK_LOCK_T = TW'(LINK_LOCK_H * 3600 * TPS);
   localparam logic [TW-1:0] FLAME_FAILURE_RESPONSE_FAST_T = TW'(FLAME_FAILURE_RESPONSE_FAST_DS * TPS / 10);
   localparam logic [TW-1:0] FLAME_FAILURE_RESPONSE_SLOW_T = TW'(FLAME_FAILURE_RESPONSE_SLOW_DS * TPS / 10);

   // ------------------------------------------------------------
   // Register map, fields and reset values
   // ------------------------------------------------------------
   localparam logic [11:0] REG_POST = 12'h000;
   localparam logic [11:0] REG_PURGE = 12'h004;
   localparam logic [11:0] REG_STATUS = 12'h008;
   localparam int POST_W = 12;
   localparam int PURGE_W = 11;
   localparam logic [POST_W-1:0] POST_RST = 12'h00f;
   localparam logic [PURGE_W-1:0] PURGE_RST = 11'h01e;
   localparam int ST_STATE_LSB = 0;
   localparam int ST_HOLD_BIT = 3;
   localparam int ST_LOCK_BIT = 4;
   localparam int ST_PERM_BIT = 5;
   localparam int ST_FAULT_LSB = 8;

   // ------------------------------------------------------------
   // Fault codes
   // ------------------------------------------------------------
   localparam logic [7:0] FLT_NONE = 8'h00;
   localparam logic [7:0] FLT_LINE = 8'h0c;
   localparam logic [7:0] FLT_FLAME_UNEXP = 8'h15;
   localparam logic [7:0] FLT_FLAME_ABS = 8'h16;
   localparam logic [7:0] FLT_AIRFLOW = 8'h1f;
   localparam logic [7:0] FLT_PREIGN = 8'h2a;
   localparam logic [7:0] FLT_LINK = 8'h6e;

   // ------------------------------------------------------------
   // States, Gray coded along the normal path
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_INIT = 3'h0,
      ST_STANDBY = 3'h1,
      ST_PREPURGE = 3'h3,
      ST_PILOT = 3'h2,
      ST_MAIN = 3'h6,
      ST_RUN = 3'h7,
      ST_POST = 3'h5,
      ST_LOCK = 3'h4
   } bss_state_e;

   // ------------------------------------------------------------
   // Burner pins
   // ------------------------------------------------------------
   typedef struct packed {
      logic line_ok;
      logic heat_call;
      logic limits_ok;
      logic airflow_interlock;
      logic preign_closed;
      logic flame;
      logic test_sel;
      logic reset_btn;
      logic flame_failure_response_slow;
      logic pilot_trial_length_link;
      logic flame_failure_action_link;
      logic airflow_failure_action_link;
   } bss_in_s;

   typedef struct packed {
      logic blower;
      logic ignition;
      logic pilot_intermit;
      logic pilot_interrupt;
      logic main_valve;
      logic delayed_main;
   } bss_out_s;

endpackage : bss_pkg

// >>> logic/bss_sync.sv
`timescale 1ns/100ps
module bss_sync #(
   parameter int W = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   // ------------------------------------------------------------
   // Three stages; a bit moves only once stages two and three agree
   // ------------------------------------------------------------
   // Agreement filters a one-cycle glitch that slipped past stage one
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               s1[i] <= 1'b0;
               s2[i] <= 1'b0;
               s3[i] <= 1'b0;
               q[i] <= 1'b0;
            end else begin
               s1[i] <= d[i];
               s2[i] <= s1[i];
               s3[i] <= s2[i];
               if (s2[i] == s3[i]) begin
                  q[i] <= s3[i];
               end
            end
         end
      end
   endgenerate

endmodule : bss_sync

// >>> sim/bss_sequencer_properties.sv
`timescale 1ns/100ps
// ----------------------------------------
// Output and timing checks at the pins
// ----------------------------------------
module bss_sequencer_properties #(
   parameter int TICK_CYC = bss_pkg::TICK_CYC,
   parameter bit VARIANT_C = 1'b0
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire bss_pkg::bss_in_s burner_in,
   input wire bss_pkg::bss_out_s burner_out,
   input wire logic lockout,
   input wire logic [7:0] fault_code
);
   localparam int TC = bss_pkg::TPS * TICK_CYC;
   int mc;
   int ic;
   int plen;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Trial lengths are counted in cycles; tick phase is free, so allow two ticks of slack
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mc <= 0;
         ic <= 0;
      end else begin
         mc <= (burner_out.main_valve && burner_out.pilot_interrupt) ? mc + 1 : 0;
         ic <= burner_out.ignition ? ic + 1 : 0;
      end
   end
   assign plen = burner_in.pilot_trial_length_link ? 10 * TC : 4 * TC;
   sequence s_drop; (!burner_in.heat_call) [*8]; endsequence
   sequence s_line; (!burner_in.line_ok) [*8]; endsequence
   chk_lock_quiet: assert property (lockout |-> burner_out == '0 && fault_code != 8'h00)
      else $error("outputs live in lockout");
   chk_trial_outs: assert property (burner_out.ignition |->
      burner_out.pilot_interrupt && burner_out.blower && !burner_out.main_valve)
      else $error("trial outputs wrong");
   chk_blower_lead: assert property ($rose(burner_out.ignition) |-> $past(burner_out.blower))
      else $error("pilot trial without purge");
   chk_main_after: assert property ($rose(burner_out.main_valve) |-> $past(burner_out.ignition))
      else $error("main valve not from trial");
   chk_main_len: assert property ($fell(burner_out.pilot_interrupt) && burner_out.main_valve
      |-> mc >= 10 * TC - 2 * TICK_CYC && mc <= 10 * TC + 2 * TICK_CYC)
      else $error("main trial length wrong");
   chk_pilot_len: assert property ($fell(burner_out.ignition) && burner_out.main_valve
      |-> ic >= plen - 2 * TICK_CYC && ic <= plen + 2 * TICK_CYC)
      else $error("pilot trial length wrong");
   chk_drop_post: assert property (s_drop |-> !burner_out.main_valve &&
      !burner_out.pilot_interrupt && !burner_out.delayed_main)
      else $error("valves on without demand");
   chk_line_init: assert property (s_line |-> burner_out == '0)
      else $error("outputs on during line fault");
   chk_delay_main: assert property (burner_out.delayed_main |-> VARIANT_C &&
      burner_out.main_valve && !burner_out.pilot_interrupt)
      else $error("delayed main out of run");
endmodule : bss_sequencer_properties

bind bss_sequencer bss_sequencer_properties #(.TICK_CYC(TICK_CYC), .VARIANT_C(VARIANT_C)) chk_u (
   .pclk(pclk), .presetn(presetn), .burner_in(burner_in), .burner_out(burner_out),
   .lockout(lockout), .fault_code(fault_code));

// >>> sim/bss_burner_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Burner hardware: airflow switch, flame, interlock
// ----------------------------------------
module bss_burner_model (
   input wire logic pclk,
   input wire bss_pkg::bss_out_s bo,
   input wire logic flame_en,
   output logic air,
   output logic pre,
   output logic flm
);
   // Pre-ignition interlock closes at once, well inside post purge
   assign pre = 1'b1;
   initial begin
      air = 1'b0;
      flm = 1'b0;
   end
   // Air proves only while the fan runs; flame burns only while fuel flows
   always @(posedge pclk) begin
      air <= bo.blower;
      flm <= flame_en & (bo.pilot_interrupt | bo.main_valve);
   end
endmodule : bss_burner_model

// >>> sim/bss_sequencer_bench.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
$display("BAD %s exp %0h got %0h", n, e, g); end end
// ----------------------------------------
// Bench: one second is 100 cycles with a 10-cycle tick
// ----------------------------------------
module bss_sequencer_bench;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, er, lockout, hold, air, pre, flm;
   logic flm_en = 1'b1;
   logic [7:0] fault_code;
   bss_pkg::bss_in_s bi = 12'ha07;
   bss_pkg::bss_out_s bo;
   wire bss_pkg::bss_in_s pins = {bi[11:9], air, pre, flm, bi[5:0]};
   int num_errors = 0;
   int samples_checked = 0;
   int seed = 32'h8f2aa14a;
   int v;
   always #5 pclk = ~pclk;
   bss_sequencer #(.TICK_CYC(10), .VARIANT_C(1'b0)) dut_u (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .burner_in(pins), .burner_out(bo),
      .lockout(lockout), .hold(hold), .fault_code(fault_code));
   bss_burner_model far_u (.pclk(pclk), .bo(bo), .flame_en(flm_en), .air(air), .pre(pre),
      .flm(flm));
   // One APB transfer; request held until pready is seen high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Let time pass, then compare the reported sequence state
   task step(input int c, input logic [2:0] s);
      repeat (c) @(posedge pclk);
      apb(1'b0, bss_pkg::REG_STATUS, 32'h0);
      `CHK("state", s, rd[2:0])
   endtask : step
   task conclude;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : conclude
   // Hang guard: the sequence needs about 9200 cycles
   initial begin
      repeat (20000) @(posedge pclk);
      num_errors++;
      conclude();
   end
   // Register checks, a full firing cycle, a failed trial, a line fault
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, bss_pkg::REG_POST, 32'h0);
      `CHK("post reset", 32'h00f, rd)
      for (int i = 0; i < 3; i++) begin
         v = $random(seed) & 32'hfff;
         apb(1'b1, bss_pkg::REG_POST, v);
         apb(1'b0, bss_pkg::REG_POST, 32'h0);
         `CHK("post", (v > 3600) ? 3600 : v, rd)
      end
      apb(1'b1, bss_pkg::REG_POST, 32'h3);
      apb(1'b1, bss_pkg::REG_PURGE, 32'h1);
      apb(1'b0, bss_pkg::REG_PURGE, 32'h0);
      `CHK("purge min", 32'h2, rd)
      apb(1'b0, 12'h00c, 32'h0);
      `CHK("unmapped", 1'b1, er)
      step(880, 3'h0);
      step(100, 3'h1);
      bi.heat_call <= 1'b1;
      step(20, 3'h3);
      `CHK("blower", 1'b1, bo.blower)
      step(950, 3'h3);
      step(80, 3'h2);
      `CHK("ignition", 1'b1, bo.ignition)
      step(900, 3'h2);
      step(80, 3'h6);
      step(900, 3'h6);
      step(80, 3'h7);
      `CHK("pilot off", 1'b0, bo.pilot_interrupt)
      bi.heat_call <= 1'b0;
      step(20, 3'h5);
      `CHK("main off", 1'b0, bo.main_valve)
      step(250, 3'h5);
      step(80, 3'h1);
      bi.pilot_trial_length_link <= 1'b0;
      flm_en <= 1'b0;
      bi.heat_call <= 1'b1;
      step(20, 3'h3);
      bi.test_sel <= 1'b1;
      step(1100, 3'h3);
      bi.test_sel <= 1'b0;
      step(1030, 3'h2);
      step(430, 3'h4);
      `CHK("fault", 8'h16, fault_code)
      // Demand off, or standby would start a new purge before it is checked
      bi.heat_call <= 1'b0;
      bi.reset_btn <= 1'b1;
      step(20, 3'h0);
      bi.reset_btn <= 1'b0;
      step(1030, 3'h1);
      bi.line_ok <= 1'b0;
      step(100, 3'h0);
      `CHK("hold", 1'b1, hold)
      bi.line_ok <= 1'b1;
      step(300, 3'h0);
      `CHK("hold shown", 1'b1, hold)
      step(600, 3'h0);
      `CHK("hold gone", 1'b0, hold)
      step(150, 3'h1);
      conclude();
   end
endmodule : bss_sequencer_bench
